// *** hw/cmp_out_pkg.sv ***
// Constants and carriers of the complementary output stage
`default_nettype none
package cmp_out_pkg;
  localparam int NCH  = 3;
  localparam int DTW  = 8;
  localparam int AW   = 12;
  localparam int SLOT = 8;

  localparam logic [AW-1:0] OFS_CTRL     = 12'h000;
  localparam logic [AW-1:0] OFS_DEADTIME = 12'h004;
  localparam logic [AW-1:0] OFS_CHCFG    = 12'h008;
  localparam logic [AW-1:0] OFS_MODE     = 12'h00c;
  localparam logic [AW-1:0] OFS_STATUS   = 12'h010;
  localparam logic [AW-1:0] OFS_IRQEN    = 12'h014;
  localparam logic [AW-1:0] OFS_EVENT    = 12'h018;
  localparam logic [AW-1:0] OFS_ACTIVE   = 12'h01c;

  localparam int ST_COM  = 0;
  localparam int ST_BRK  = 1;
  localparam int EV_COMMUTATION_GENERATE = 0;

  localparam logic [2:0] MODE_FORCE_INACT = 3'h4;
  localparam logic [2:0] MODE_FORCE_ACT   = 3'h5;

  localparam logic [1:0] LOCK_OFF = 2'h0;
  localparam logic [1:0] LOCK_L2  = 2'h2;

  // Bits 7..0 of the control register
  typedef struct packed {
    logic [1:0] lock;
    logic       off_state_in_run;
    logic       off_state_in_idle;
    logic       break_polarity;
    logic       break_enable;
    logic       automatic_output_enable;
    logic       master_output_enable;
  } ctrl_s;

  // Bits 5..0 of each channel slot
  typedef struct packed {
    logic cen;
    logic men;
    logic cidle;
    logic midle;
    logic cpol;
    logic mpol;
  } chcfg_s;

  typedef struct packed {
    logic [1:0]     tgt;
    logic [1:0]     pend;
    logic [DTW-1:0] cnt;
  } dt_state_s;

  typedef struct packed {
    logic           moe_r1;
    logic           moe_r2;
    logic [NCH-1:0] m_act;
    logic [NCH-1:0] c_act;
  } async_s;

  typedef struct packed {
    ctrl_s               ctrl;
    logic                lock_done;
    logic [DTW-1:0]      dt;
    chcfg_s [NCH-1:0]    cfg;
    logic [NCH-1:0][2:0] mode;
    logic [NCH-1:0]      men_a;
    logic [NCH-1:0]      cen_a;
    logic [NCH-1:0][2:0] mode_a;
    logic                com_flag;
    logic                brk_flag;
    logic                com_ie;
    logic                brk_ie;
    logic                trig_q;
    logic                brk_s1;
    logic                brk_s2;
    logic                brk_s3;
    logic [NCH-1:0]      oe_m;
    logic [NCH-1:0]      oe_c;
    logic                irq_c;
    logic                irq_b;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } top_state_s;

  localparam top_state_s TOP_RST = '0;
endpackage
`default_nettype wire

// *** hw/deadtime_unit.sv ***
// Deadtime generator for one main and complementary pair
`timescale 1ns/1ps
`default_nettype none
module deadtime_unit
  import cmp_out_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Wanted active levels, bit 0 main, bit 1 complementary
  input  wire logic [1:0]     tgt,
  input  wire logic           use_dt,
  input  wire logic [DTW-1:0] dt,
  // Active levels after deadtime
  output logic      [1:0]     act
);
  dt_state_s s_ff;
  dt_state_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (tgt != s_ff.tgt) begin
      nxt_s.tgt = tgt;
      nxt_s.cnt = dt;
      nxt_s.pend = (use_dt && dt != '0) ? (tgt & ~s_ff.tgt) : 2'h0;
    end else if (s_ff.cnt != '0) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end else begin
      nxt_s.pend = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // A pulse shorter than the delay restarts the count and never shows
  assign act = s_ff.tgt & ~s_ff.pend;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_count_down;
    (s_ff.cnt != '0 && tgt == s_ff.tgt) |=>
      (s_ff.cnt == $past(s_ff.cnt) - 1'b1);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("deadtime count did not step");
endmodule // deadtime_unit
`default_nettype wire

// *** hw/cmp_out_stage.sv ***
// Complementary output stage with deadtime, commutation and break
`timescale 1ns/1ps
`default_nettype none
module cmp_out_stage
  import cmp_out_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [AW-1:0]  paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Timer events
  input  wire logic [NCH-1:0] reference_waveform,
  input  wire logic           trigger_input,
  input  wire logic           update_event,
  input  wire logic           break_pin,
  // Channel pins
  output logic      [NCH-1:0] main_output,
  output logic      [NCH-1:0] main_output_oe,
  output logic      [NCH-1:0] complementary_output,
  output logic      [NCH-1:0] complementary_output_oe,
  // Interrupt requests
  output logic                commutation_irq,
  output logic                break_irq
);
  top_state_s          s_ff;
  top_state_s          nxt_s;
  async_s              a_ff;
  async_s              nxt_a;
  ctrl_s               wctrl;
  logic                brk;
  logic                clr_n;
  logic                acc;
  logic                hit;
  logic                wr;
  logic                wr_ctrl;
  logic                wr_st;
  logic                commutation_event;
  logic                moe_run;
  logic                lk1;
  logic                lk2;
  logic                lk3;
  logic [31:0]         rd_cfg;
  logic [31:0]         rd_mode;
  logic [31:0]         rd_act;
  logic [31:0]         rdata;
  chcfg_s [NCH-1:0]    cfg_wr;
  logic [NCH-1:0][2:0] mode_wr;
  logic [NCH-1:0]      mpol_v;
  logic [NCH-1:0]      cpol_v;
  logic [NCH-1:0]      pre_men;
  logic [NCH-1:0]      pre_cen;
  logic [NCH-1:0]      oe_m_w;
  logic [NCH-1:0]      oe_c_w;
  logic [NCH-1:0]      m_dt;
  logic [NCH-1:0]      c_dt;

  // Asynchronous path; enable and polarity are quasi-static settings
  assign brk = s_ff.ctrl.break_enable & (break_pin == s_ff.ctrl.break_polarity);
  // Held until the synchronous side has switched targets to idle
  assign clr_n = presetn & ~(brk & ~s_ff.brk_s3);
  assign moe_run = ~s_ff.brk_s2 &
                   (a_ff.moe_r2 | (brk & s_ff.ctrl.master_output_enable));
  assign lk1 = s_ff.ctrl.lock != LOCK_OFF;
  assign lk2 = s_ff.ctrl.lock >= LOCK_L2;
  assign lk3 = s_ff.ctrl.lock > LOCK_L2;

  assign acc = psel & penable;
  assign hit = (paddr[1:0] == 2'h0) && (paddr <= OFS_ACTIVE);
  assign wr = acc & s_ff.pready & pwrite & hit;
  assign wr_ctrl = wr && (paddr == OFS_CTRL);
  assign wr_st = wr && (paddr == OFS_STATUS);
  assign wctrl = ctrl_s'(pwdata[7:0]);
  assign commutation_event = (wr && paddr == OFS_EVENT && pwdata[EV_COMMUTATION_GENERATE]) |
               (trigger_input & ~s_ff.trig_q);

  assign rd_cfg[31:SLOT*NCH] = '0;
  assign rd_mode[31:SLOT*NCH] = '0;
  assign rd_act[31:SLOT*NCH] = '0;

  genvar i;
  for (i = 0; i < NCH; i++) begin : g_ch
    chcfg_s     w;
    chcfg_s     c;
    logic       ref_eff;
    logic       m_idle;
    logic       c_idle;
    logic       use_dt;
    logic [1:0] tgt;

    assign w = chcfg_s'(pwdata[SLOT*i +: $bits(chcfg_s)]);
    assign c = s_ff.cfg[i];
    assign cfg_wr[i] = '{cen: w.cen, men: w.men,
                         cidle: lk1 ? c.cidle : w.cidle,
                         midle: lk1 ? c.midle : w.midle,
                         cpol: lk2 ? c.cpol : w.cpol,
                         mpol: lk2 ? c.mpol : w.mpol};
    assign mode_wr[i] = lk3 ? s_ff.mode[i] : pwdata[SLOT*i +: 3];
    assign rd_cfg[SLOT*i +: SLOT] = {2'h0, c};
    assign rd_mode[SLOT*i +: SLOT] = {5'h0, s_ff.mode[i]};
    assign rd_act[SLOT*i +: SLOT] = {2'h0, s_ff.cen_a[i], s_ff.men_a[i],
                                     1'b0, s_ff.mode_a[i]};
    assign mpol_v[i] = c.mpol;
    assign cpol_v[i] = c.cpol;
    assign pre_men[i] = c.men;
    assign pre_cen[i] = c.cen;

    // Forced modes override the incoming reference
    assign ref_eff = (s_ff.mode_a[i] == MODE_FORCE_ACT) |
                     ((s_ff.mode_a[i] != MODE_FORCE_INACT) &
                      reference_waveform[i]);
    assign m_idle = c.midle ^ c.mpol;
    // Idle levels never let both switches conduct
    assign c_idle = (c.cidle ^ c.cpol) & ~m_idle;

    always_comb begin
      tgt = 2'h0;
      use_dt = 1'b1;
      if (!moe_run) begin
        tgt = {c_idle, m_idle};
      end else if (brk) begin
        // Follow the cleared pins so idle entry restarts the deadtime
        tgt = 2'h0;
      end else begin
        unique case ({s_ff.cen_a[i], s_ff.men_a[i]})
          2'b11: tgt = {~ref_eff, ref_eff};
          2'b01: begin
            tgt = {1'b0, ref_eff};
            use_dt = 1'b0;
          end
          2'b10: begin
            tgt = {ref_eff, 1'b0};
            use_dt = 1'b0;
          end
          2'b00: use_dt = 1'b0;
        endcase
      end
    end

    assign oe_m_w[i] = moe_run ? (s_ff.men_a[i] | s_ff.ctrl.off_state_in_run)
                               : s_ff.ctrl.off_state_in_idle;
    assign oe_c_w[i] = moe_run ? (s_ff.cen_a[i] | s_ff.ctrl.off_state_in_run)
                               : s_ff.ctrl.off_state_in_idle;

    deadtime_unit u_dt (
      .clk    (pclk),
      .rst_n  (presetn),
      .tgt    (tgt),
      .use_dt (use_dt),
      .dt     (s_ff.dt),
      .act    ({c_dt[i], m_dt[i]})
    );
  end

  always_comb begin
    case (paddr)
      OFS_CTRL:     rdata = {24'h0, s_ff.ctrl[7:1], a_ff.moe_r2};
      OFS_DEADTIME: rdata = {24'h0, s_ff.dt};
      OFS_CHCFG:    rdata = rd_cfg;
      OFS_MODE:     rdata = rd_mode;
      OFS_STATUS:   rdata = {30'h0, s_ff.brk_flag, s_ff.com_flag};
      OFS_IRQEN:    rdata = {30'h0, s_ff.brk_ie, s_ff.com_ie};
      OFS_ACTIVE:   rdata = rd_act;
      default:      rdata = '0;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.trig_q = trigger_input;
    nxt_s.brk_s1 = brk;
    nxt_s.brk_s2 = s_ff.brk_s1;
    nxt_s.brk_s3 = s_ff.brk_s2;
    // One wait state: answer in the second access cycle
    if (acc && !s_ff.pready) begin
      nxt_s.pready = 1'b1;
      nxt_s.prdata = rdata;
      nxt_s.pslverr = ~hit;
    end else begin
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;
    end
    if (wr_ctrl) begin
      nxt_s.lock_done = 1'b1;
      if (!s_ff.lock_done) begin
        nxt_s.ctrl.lock = wctrl.lock;
      end
      if (!lk1) begin
        nxt_s.ctrl.break_enable = wctrl.break_enable;
        nxt_s.ctrl.break_polarity = wctrl.break_polarity;
        nxt_s.ctrl.automatic_output_enable = wctrl.automatic_output_enable;
      end
      if (!lk2) begin
        nxt_s.ctrl.off_state_in_idle = wctrl.off_state_in_idle;
        nxt_s.ctrl.off_state_in_run = wctrl.off_state_in_run;
      end
    end
    // Break outranks every way of raising the enable
    if (s_ff.brk_s2) begin
      nxt_s.ctrl.master_output_enable = 1'b0;
    end else if (wr_ctrl) begin
      nxt_s.ctrl.master_output_enable = wctrl.master_output_enable;
    end else if (s_ff.ctrl.automatic_output_enable && update_event) begin
      nxt_s.ctrl.master_output_enable = 1'b1;
    end
    if (wr && paddr == OFS_DEADTIME) begin
      nxt_s.dt = pwdata[DTW-1:0];
    end
    if (wr && paddr == OFS_CHCFG) begin
      nxt_s.cfg = cfg_wr;
    end
    if (wr && paddr == OFS_MODE) begin
      nxt_s.mode = mode_wr;
    end
    if (wr && paddr == OFS_IRQEN) begin
      nxt_s.com_ie = pwdata[ST_COM];
      nxt_s.brk_ie = pwdata[ST_BRK];
    end
    if (commutation_event) begin
      nxt_s.men_a = pre_men;
      nxt_s.cen_a = pre_cen;
      nxt_s.mode_a = s_ff.mode;
    end
    // Writing zero clears; a new event in the same cycle wins
    nxt_s.com_flag = commutation_event |
      (s_ff.com_flag & ~(wr_st & ~pwdata[ST_COM]));
    nxt_s.brk_flag = s_ff.brk_s2 |
      (s_ff.brk_flag & ~(wr_st & ~pwdata[ST_BRK]));
    nxt_s.irq_c = nxt_s.com_flag & nxt_s.com_ie;
    nxt_s.irq_b = nxt_s.brk_flag & nxt_s.brk_ie;
    nxt_s.oe_m = oe_m_w;
    nxt_s.oe_c = oe_c_w;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= TOP_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    nxt_a.moe_r1 = s_ff.ctrl.master_output_enable & ~s_ff.brk_s2;
    nxt_a.moe_r2 = a_ff.moe_r1;
    nxt_a.m_act = m_dt;
    nxt_a.c_act = c_dt;
  end

  // Cleared by break even with no clock running
  always_ff @(posedge pclk or negedge clr_n) begin
    if (!clr_n) begin
      a_ff <= '0;
    end else begin
      a_ff <= nxt_a;
    end
  end

  assign main_output = a_ff.m_act ^ mpol_v;
  assign complementary_output = a_ff.c_act ^ cpol_v;
  assign main_output_oe = s_ff.oe_m;
  assign complementary_output_oe = s_ff.oe_c;
  assign commutation_irq = s_ff.irq_c;
  assign break_irq = s_ff.irq_b;
  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_no_overlap;
    (a_ff.m_act & a_ff.c_act) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("main and complementary active together");

  property p_brk_async;
    (brk && !s_ff.brk_s2) |->
      (!a_ff.moe_r2 && a_ff.m_act == '0 && a_ff.c_act == '0);
  endproperty
  a_brk_async: assert property (p_brk_async)
    else $error("break did not clear outputs");

  property p_brk_hold;
    s_ff.brk_s2 |=> (!s_ff.ctrl.master_output_enable && s_ff.brk_flag);
  endproperty
  a_brk_hold: assert property (p_brk_hold)
    else $error("enable set or flag lost during break");

  property p_idle_late;
    $rose(s_ff.brk_s2) |-> ((a_ff.m_act | a_ff.c_act) == '0)[*2];
  endproperty
  a_idle_late: assert property (p_idle_late)
    else $error("idle driven too early after break");

  property p_com_flag;
    commutation_event |=> s_ff.com_flag;
  endproperty
  a_com_flag: assert property (p_com_flag)
    else $error("commutation flag not set");

  property p_com_copy;
    commutation_event |=> (s_ff.mode_a == $past(s_ff.mode) &&
             s_ff.men_a == $past(pre_men));
  endproperty
  a_com_copy: assert property (p_com_copy)
    else $error("preload not copied on commutation");

  property p_trig_com;
    $rose(trigger_input) |=> s_ff.com_flag;
  endproperty
  a_trig_com: assert property (p_trig_com)
    else $error("trigger rise gave no commutation");

  property p_aoe;
    (s_ff.ctrl.automatic_output_enable && update_event && !s_ff.brk_s2 && !wr_ctrl) |=>
      s_ff.ctrl.master_output_enable;
  endproperty
  a_aoe: assert property (p_aoe)
    else $error("auto enable did not restore");

  property p_moe_sync;
    $rose(s_ff.ctrl.master_output_enable) ##1 (s_ff.ctrl.master_output_enable && !brk)[*2] |->
      a_ff.moe_r2;
  endproperty
  a_moe_sync: assert property (p_moe_sync)
    else $error("enable not seen two clocks later");

  property p_lock_once;
    (s_ff.lock_done && wr_ctrl) |=> $stable(s_ff.ctrl.lock);
  endproperty
  a_lock_once: assert property (p_lock_once)
    else $error("lock field changed twice");

  property p_idle_oe;
    !moe_run |=> main_output_oe == {NCH{$past(s_ff.ctrl.off_state_in_idle)}};
  endproperty
  a_idle_oe: assert property (p_idle_oe)
    else $error("idle enable differs from setting");

  property p_cov_com;
    commutation_event ##1 commutation_irq;
  endproperty
  c_com: cover property (p_cov_com);

  property p_cov_brk;
    $rose(s_ff.brk_s2) ##3 (a_ff.m_act | a_ff.c_act) != '0;
  endproperty
  c_brk: cover property (p_cov_brk);

  property p_cov_aoe;
    s_ff.brk_flag && s_ff.ctrl.automatic_output_enable ##1 $rose(s_ff.ctrl.master_output_enable);
  endproperty
  c_aoe: cover property (p_cov_aoe);
endmodule // cmp_out_stage
`default_nettype wire

// *** tb/drive_stage_model.sv ***
// Power switch drivers and break alarm source beside the output stage
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model
  import cmp_out_pkg::*;
(
  // Clock
  input  wire logic           pclk,
  // Pins of the stage, watched with polarity 0
  input  wire logic [NCH-1:0] main_output,
  input  wire logic [NCH-1:0] complementary_output,
  input  wire logic           watch,
  // Alarm source
  input  wire logic           alarm,
  input  wire logic           alarm_level,
  output logic                break_pin,
  output int                  n_overlap
);
  // Alarm is a level held until the fault clears
  assign break_pin = alarm ? alarm_level : ~alarm_level;
  initial n_overlap = 0;
  // Both switches of one leg on together would short the supply
  always @(negedge pclk) begin
    if (watch && |(main_output & complementary_output)) begin
      n_overlap <= n_overlap + 1;
    end
  end
endmodule // drive_stage_model
`default_nettype wire

// *** tb/tb_complementary_output_deadtime_break.sv ***
// Self-checking bench of the complementary output stage
`timescale 1ns/1ps
`default_nettype none
module tb_complementary_output_deadtime_break;
  import cmp_out_pkg::*;
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic           pwrite = 0, pready, pslverr, err, hit;
  logic [AW-1:0]  paddr = '0;
  logic [31:0]    pwdata = '0, prdata, rd;
  logic [NCH-1:0] mo, mo_oe, co, co_oe;
  logic [1:0]     rr = '0;
  logic           r0 = 0, trig = 0, upd = 0, cirq, birq, brk;
  logic           alarm = 0, alvl = 1, watch = 0;
  int             n_mismatch = 0, n_compared = 0, n_overlap, dt, tm, tc;

  always #12.5 pclk = ~pclk;
  // Other channels run on random references
  always @(posedge pclk) rr <= 2'($urandom);

  cmp_out_stage dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_waveform({rr, r0}), .trigger_input(trig),
    .update_event(upd), .break_pin(brk), .main_output(mo),
    .main_output_oe(mo_oe), .complementary_output(co),
    .complementary_output_oe(co_oe), .commutation_irq(cirq),
    .break_irq(birq));
  drive_stage_model far (.pclk(pclk), .main_output(mo),
    .complementary_output(co), .watch(watch), .alarm(alarm),
    .alarm_level(alvl), .break_pin(brk), .n_overlap(n_overlap));

  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic reset_dut;
    @(posedge pclk);
    presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
  endtask

  // Request held until the edge where pready is seen high
  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    // Values read here are those sampled at this rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Edges from a reference step to the change of each pin
  task automatic step(input logic v);
    @(posedge pclk);
    r0 <= v;
    tm = 0;
    tc = 0;
    for (int k = 1; k < 200; k++) begin
      @(negedge pclk);
      if (tm == 0 && mo[0] === v) tm = k;
      if (tc == 0 && co[0] === !v) tc = k;
    end
  endtask

  function automatic int on_delay(input int n);
    return n + 4;
  endfunction

  initial begin
    #(25 * 40000);
    n_mismatch++;
    final_report();
  end

  initial begin
    void'($urandom(74018));
    reset_dut();
    apb(0, OFS_CTRL, 0);
    check(rd, 0);
    check({mo, co, mo_oe, co_oe}, 0);
    apb(1, OFS_CHCFG, 32'h303030);
    apb(1, OFS_IRQEN, 32'h3);
    apb(1, OFS_EVENT, 32'h1);
    apb(0, OFS_ACTIVE, 0);
    check(rd, 32'h303030);
    apb(0, OFS_STATUS, 0);
    check(rd[0], 1);
    check(cirq, 1);
    apb(1, OFS_STATUS, 0);
    apb(1, OFS_CTRL, 32'h1);
    apb(0, OFS_CTRL, 0);
    check(rd[0], 1);
    watch = 1;
    repeat (4) begin
      dt = $urandom_range(3, 40);
      apb(1, OFS_DEADTIME, 32'(dt));
      r0 <= 0;
      repeat (50) @(posedge pclk);
      step(1);
      check(tm, on_delay(dt));
      check(tc, 3);
      step(0);
      check(tm, 3);
      check(tc, on_delay(dt));
      for (int v = 1; v >= 0; v--) begin
        @(posedge pclk);
        r0 <= !v[0];
        repeat (dt + 8) @(posedge pclk);
        r0 <= v[0];
        @(posedge pclk);
        r0 <= !v[0];
        hit = 0;
        repeat (dt + 8) begin
          @(negedge pclk);
          hit |= v ? mo[0] : co[0];
        end
        check(hit, 0);
      end
    end
    // Single enable routes the reference past the deadtime
    for (int i = 0; i < 2; i++) begin
      apb(1, OFS_CHCFG, i ? 32'h10 : 32'h20);
      @(posedge pclk);
      trig <= 1;
      repeat (3) @(posedge pclk);
      trig <= 0;
      apb(0, OFS_ACTIVE, 0);
      check(rd, i ? 32'h10 : 32'h20);
      @(posedge pclk);
      r0 <= 1;
      repeat (4) @(negedge pclk);
      check({mo[0], co[0]}, i ? 2'b10 : 2'b01);
      @(posedge pclk);
      r0 <= 0;
      repeat (4) @(negedge pclk);
      check({mo[0], co[0]}, 0);
    end
    // Forced modes override the reference on the main-only channel
    apb(1, OFS_MODE, 32'(MODE_FORCE_ACT));
    apb(1, OFS_EVENT, 32'h1);
    repeat (4) @(negedge pclk);
    check({mo[0], co[0]}, 2'b10);
    @(posedge pclk);
    r0 <= 1;
    apb(1, OFS_MODE, 32'(MODE_FORCE_INACT));
    apb(1, OFS_EVENT, 32'h1);
    repeat (4) @(negedge pclk);
    check({mo[0], co[0]}, 2'b00);
    @(posedge pclk);
    r0 <= 0;
    apb(1, OFS_MODE, 32'h0);
    watch = 0;
    apb(1, OFS_CHCFG, 32'h33);
    apb(1, OFS_EVENT, 32'h1);
    repeat (dt + 10) @(posedge pclk);
    check({mo[0], co[0]}, 2'b10);
    apb(1, OFS_CHCFG, 32'h34);
    apb(1, OFS_CTRL, 32'h1d);
    r0 <= 1;
    repeat (dt + 10) @(posedge pclk);
    watch = 1;
    // Break arrives between clock edges
    #3 alarm = 1;
    #1 check({mo[0], co[0]}, 0);
    repeat (3) @(negedge pclk);
    check(mo[0], 0);
    // Idle level waits a full deadtime after the synchronised break
    repeat (dt) @(negedge pclk);
    check(mo[0], 0);
    repeat (12) @(negedge pclk);
    check({mo[0], co[0], mo_oe[0], co_oe[0]}, 4'b1011);
    check(birq, 1);
    apb(1, OFS_CTRL, 32'h1d);
    apb(0, OFS_CTRL, 0);
    check(rd[0], 0);
    apb(1, OFS_STATUS, 0);
    apb(0, OFS_STATUS, 0);
    check(rd[1], 1);
    alarm <= 0;
    apb(1, OFS_STATUS, 0);
    apb(0, OFS_STATUS, 0);
    check(rd[1], 0);
    apb(1, OFS_CTRL, 32'h1e);
    apb(0, OFS_CTRL, 0);
    check(rd[0], 0);
    @(posedge pclk);
    upd <= 1;
    @(posedge pclk);
    upd <= 0;
    apb(0, OFS_CTRL, 0);
    check(rd[0], 1);
    // Lock taken from the first control write after reset
    reset_dut();
    apb(1, OFS_CTRL, 32'h88);
    apb(1, OFS_CTRL, 32'h04);
    apb(0, OFS_CTRL, 0);
    check(rd[7:0], 8'h88);
    apb(1, OFS_CHCFG, 32'h1);
    apb(0, OFS_CHCFG, 0);
    check(rd, 0);
    apb(1, OFS_DEADTIME, 32'h5);
    apb(0, OFS_DEADTIME, 0);
    check(rd, 32'h5);
    apb(0, 12'h020, 0);
    check({err, rd[30:0]}, 32'h80000000);
    check(n_overlap, 0);
    final_report();
  end
endmodule // tb_complementary_output_deadtime_break
`default_nettype wire
